// ==== pkg/erq_pkg.sv ====
package erq_pkg;

  // Width of a stored signed error code (-512..+511 covers every code)
  localparam int ERQ_CODE_W = 10;
  // Queue capacity
  localparam int ERQ_DEPTH = 20;
  // Longest legal header keyword
  localparam logic [3:0] ERQ_HDR_MAX = 4'hC;
  // Most significant mantissa digits allowed (255)
  localparam logic [8:0] ERQ_DIG_MAX = 9'h0FF;
  // Largest legal exponent value (32000)
  localparam logic [19:0] ERQ_EXP_MAX = 20'h07D00;
  // Highest sub-code of the block and expression ranges
  localparam logic [3:0] ERQ_SUB_MAX = 4'h8;

  // Clock rate and front-panel viewer timeout
  localparam longint ERQ_CLK_HZ = 100_000_000;
  localparam longint ERQ_VIEW_TMO_S = 30;
  localparam longint ERQ_VIEW_TMO_CYC = ERQ_VIEW_TMO_S * ERQ_CLK_HZ;

  // Characters the lexer looks at or the reply sends
  localparam logic [7:0] ERQ_CH_HASH = 8'h23;
  localparam logic [7:0] ERQ_CH_DOLLAR = 8'h24;
  localparam logic [7:0] ERQ_CH_PCT = 8'h25;
  localparam logic [7:0] ERQ_CH_SP = 8'h20;
  localparam logic [7:0] ERQ_CH_COLON = 8'h3A;
  localparam logic [7:0] ERQ_CH_COMMA = 8'h2C;
  localparam logic [7:0] ERQ_CH_QUOTE = 8'h22;
  localparam logic [7:0] ERQ_CH_PLUS = 8'h2B;
  localparam logic [7:0] ERQ_CH_MINUS = 8'h2D;
  localparam logic [7:0] ERQ_CH_DOT = 8'h2E;
  localparam logic [7:0] ERQ_CH_ZERO = 8'h30;
  localparam logic [7:0] ERQ_CH_NINE = 8'h39;
  localparam logic [7:0] ERQ_CH_E_UP = 8'h45;
  localparam logic [7:0] ERQ_CH_E_LO = 8'h65;
  localparam logic [7:0] ERQ_CH_NUL = 8'h00;

  // Error kinds; the ordinal doubles as the message text index
  typedef enum logic [4:0] {
    ERQ_K_NONE, ERQ_K_INV_CHAR, ERQ_K_SYNTAX, ERQ_K_SEPAR, ERQ_K_DTYPE,
    ERQ_K_GET, ERQ_K_PARM_EXTRA, ERQ_K_PARM_MISS, ERQ_K_MNEM_LONG,
    ERQ_K_UNDEF_HDR, ERQ_K_NUM_CHAR, ERQ_K_NUM_OVF, ERQ_K_DIGITS,
    ERQ_K_NUM_NOT, ERQ_K_SUF_INV, ERQ_K_SUF_LONG, ERQ_K_SUF_NOT,
    ERQ_K_BLOCK, ERQ_K_EXPR, ERQ_K_TOO_MANY
  } erq_kind_e;

  // Signed code of a kind; sub picks the member of a code range
  function automatic logic signed [ERQ_CODE_W-1:0] erq_code(input erq_kind_e k,
                                                            input logic [3:0] sub);
    logic [ERQ_CODE_W-1:0] m;
    logic [3:0] s;
    s = (sub > ERQ_SUB_MAX) ? ERQ_SUB_MAX : sub;
    case (k)
      ERQ_K_INV_CHAR: m = 10'h065;
      ERQ_K_SYNTAX: m = 10'h066;
      ERQ_K_SEPAR: m = 10'h067;
      ERQ_K_DTYPE: m = 10'h068;
      ERQ_K_GET: m = 10'h069;
      ERQ_K_PARM_EXTRA: m = 10'h06C;
      ERQ_K_PARM_MISS: m = 10'h06D;
      ERQ_K_MNEM_LONG: m = 10'h070;
      ERQ_K_UNDEF_HDR: m = 10'h071;
      ERQ_K_NUM_CHAR: m = 10'h079;
      ERQ_K_NUM_OVF: m = 10'h07B;
      ERQ_K_DIGITS: m = 10'h07C;
      ERQ_K_NUM_NOT: m = 10'h080;
      ERQ_K_SUF_INV: m = 10'h083;
      ERQ_K_SUF_LONG: m = 10'h086;
      ERQ_K_SUF_NOT: m = 10'h08A;
      ERQ_K_BLOCK: m = 10'h0A0 + {6'h00, s};
      ERQ_K_EXPR: m = 10'h0AA + {6'h00, s};
      ERQ_K_TOO_MANY: m = 10'h15E;
      default: m = 10'h000;
    endcase
    return $signed(-m);
  endfunction

endpackage

// ==== rtl/erq_queue.sv ====
`timescale 1ns/1ps
// Arrival-ordered store of error records with overflow marking
module erq_queue import erq_pkg::*; #(
  parameter int DEPTH = ERQ_DEPTH,
  parameter int PW = $clog2(DEPTH),
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_push,
  input wire logic signed [ERQ_CODE_W-1:0] i_push_code,
  input wire erq_kind_e i_push_kind,
  input wire logic i_pop,
  input wire logic [PW-1:0] i_peek_sel,
  output logic signed [ERQ_CODE_W-1:0] o_head_code,
  output erq_kind_e o_head_kind,
  output logic signed [ERQ_CODE_W-1:0] o_peek_code,
  output logic o_empty,
  output logic o_full,
  output logic o_ovf
);

  // Record storage, no reset needed: occupancy is tracked by the count
  logic signed [ERQ_CODE_W-1:0] mem_code_q [DEPTH];
  erq_kind_e mem_kind_q [DEPTH];
  logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;

  // Modulo-DEPTH pointer step
  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [PW-1:0] n);
    logic [PW:0] s;
    s = {1'b0, p} + {1'b0, n};
    return (s >= DEPTH) ? PW'(s - DEPTH) : s[PW-1:0];
  endfunction

  wire pop_ok = i_pop && !o_empty;
  // A pop in the same cycle frees the room the push needs
  wire acc = i_push && (!o_full || i_pop);
  // Full and not yet marked: the newest slot becomes the overflow marker
  wire ovw = i_push && o_full && !i_pop && !ovf_q;
  wire [PW-1:0] last_slot = ptr_add(wr_q, PW'(DEPTH - 1));
  wire [PW-1:0] peek_slot = ptr_add(rd_q, i_peek_sel);
  // Entry that becomes the head once the current head is read out
  wire signed [ERQ_CODE_W-1:0] next_code = mem_code_q[ptr_add(rd_q, PW'(1))];

  assign o_empty = (cnt_q == '0);
  assign o_full = (cnt_q == CW'(DEPTH));
  assign o_ovf = ovf_q;
  assign o_head_code = mem_code_q[rd_q];
  assign o_head_kind = mem_kind_q[rd_q];
  assign o_peek_code = (CW'(i_peek_sel) < cnt_q) ? mem_code_q[peek_slot] : '0;

  // Clear wins over every other queue action
  assign wr_d = i_clear ? '0 : (acc ? ptr_add(wr_q, PW'(1)) : wr_q);
  assign rd_d = i_clear ? '0 : (pop_ok ? ptr_add(rd_q, PW'(1)) : rd_q);
  assign cnt_d = i_clear ? '0 : CW'(cnt_q + CW'(acc) - CW'(pop_ok));
  // Marker blocks storage until a record leaves by reading
  assign ovf_d = i_clear ? 1'b0 : (pop_ok ? 1'b0 : (ovw ? 1'b1 : ovf_q));

  // Record write: new entry at the tail, or marker over the newest
  always_ff @(posedge i_mclk) begin
    if (acc) begin
      mem_code_q[wr_q] <= i_push_code;
      mem_kind_q[wr_q] <= i_push_kind;
    end else if (ovw) begin
      mem_code_q[last_slot] <= erq_code(ERQ_K_TOO_MANY, 4'h0);
      mem_kind_q[last_slot] <= ERQ_K_TOO_MANY;
    end
  end

  // Pointers and flags
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  a_ovf_marks: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (ovw && !i_clear) |=> (o_ovf && o_full && mem_code_q[$past(last_slot)] == -10'sh15E))
    else $error("overflow marker not placed in newest slot");

  a_ovf_discard: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (ovf_q && i_push && !i_pop && !i_clear) |=> ($stable(cnt_q) && $stable(wr_q)))
    else $error("error stored while overflow marker stands");

  a_fifo_order: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (pop_ok && !i_clear && cnt_q > CW'(1)) |=> (o_head_code == $past(next_code)))
    else $error("queue did not advance to the next oldest entry");

endmodule

// ==== rtl/erq_checker.sv ====
`timescale 1ns/1ps
// What this block does
// - Errors read back oldest first
// - A remote read removes the delivered entry
// - Indicator lit while queue holds entries
// - One beep per cycle with a new error, stored or not
// - Full queue: newest entry becomes -350
// - After marker, drop errors until a read
// - Empty read gives +0; panel shows none
// - Clear-status command and power-up empty queue
// - Device reset command leaves queue alone
// - Viewer exit or timeout empties queue
// - Reply: signed code, comma, quoted message
// - Illegal character queues -101
// - Blank around header colon or before comma: -102
// - Wrong separator queues -103
// - Wrong parameter type -104, number for string -128
// - Trigger message inside command queues -105
// - Extra parameter -108, missing parameter -109
// - Header keyword over twelve characters: -112
// - Unknown header queues -113
// - Bad character inside number queues -121
// - Exponent over 32000 -123, 256+ digits -124
// - Suffix misspelled -131, long -134, unwanted -138
// - Block data -160..-168, expressions -170..-178
module erq_checker import erq_pkg::*; #(
  parameter int DEPTH = ERQ_DEPTH,
  parameter int PW = $clog2(DEPTH),
  parameter logic [31:0] P_VIEW_TMO_CYC = 32'(ERQ_VIEW_TMO_CYC)
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ch_valid,
  input wire logic [7:0] i_ch,
  input wire logic i_ch_eoc,
  input wire logic i_get,
  input wire logic i_dec_valid,
  input wire erq_kind_e i_dec_kind,
  input wire logic [3:0] i_dec_sub,
  input wire logic i_err_rd,
  input wire logic i_cls,
  input wire logic i_view_key,
  input wire logic i_view_knob,
  input wire logic [PW-1:0] i_view_sel,
  output logic o_beep,
  output logic o_err_lit,
  output logic o_tx_valid,
  output logic [7:0] o_tx_char,
  output logic o_tx_msg,
  output erq_kind_e o_tx_idx,
  output logic o_tx_last,
  output logic signed [ERQ_CODE_W-1:0] o_view_code,
  output logic o_view_none
);

  // Reply character sequencer states
  typedef enum logic [3:0] {
    TX_IDLE, TX_SIGN, TX_D2, TX_D1, TX_D0, TX_COMMA, TX_OQ, TX_MSG, TX_CQ
  } erq_tx_e;

  // Lexer state
  logic in_cmd_q, in_prm_q, prev_sp_q, prev_col_q, tok_st_q;
  logic in_num_q, in_exp_q, lead_q, gap_q, lex_flt_q;
  logic [3:0] hdr_len_q, hdr_len_d;
  logic [8:0] dig_cnt_q, dig_cnt_d;
  logic [19:0] exp_q, exp_d;
  // Viewer state
  logic view_q;
  logic [31:0] tmr_q;
  // Reply state
  erq_tx_e tx_q, tx_d;
  logic signed [ERQ_CODE_W-1:0] rec_code_q;
  erq_kind_e rec_kind_q;
  // Output flops
  logic beep_q, lit_q, txv_q, txm_q, txl_q, vnone_q;
  logic [7:0] txc_q;
  erq_kind_e txi_q;
  logic signed [ERQ_CODE_W-1:0] vcode_q;
  // Queue side
  logic signed [ERQ_CODE_W-1:0] q_head_code, q_peek_code;
  erq_kind_e q_head_kind;
  logic q_empty, q_full, q_ovf;

  // Character classes
  wire ch_go = i_ch_valid && !i_ch_eoc;
  wire ch_dig = (i_ch >= ERQ_CH_ZERO) && (i_ch <= ERQ_CH_NINE);
  wire ch_bad = (i_ch == ERQ_CH_HASH) || (i_ch == ERQ_CH_DOLLAR) || (i_ch == ERQ_CH_PCT);
  wire ch_sp = (i_ch == ERQ_CH_SP);
  wire ch_col = (i_ch == ERQ_CH_COLON);
  wire ch_com = (i_ch == ERQ_CH_COMMA);
  wire ch_pm = (i_ch == ERQ_CH_PLUS) || (i_ch == ERQ_CH_MINUS);
  wire ch_exp = (i_ch == ERQ_CH_E_UP) || (i_ch == ERQ_CH_E_LO);
  wire ch_numst = ch_dig || ch_pm || (i_ch == ERQ_CH_DOT);
  wire ch_kw = !ch_sp && !ch_col && !ch_com;
  wire [3:0] dig_v = i_ch[3:0];

  // Number tracking: starts on a numeric token start, ends on a non-numeric char
  wire num_now = in_num_q ? (ch_numst || ch_exp) : (in_prm_q && tok_st_q && ch_numst);
  wire eff_lead = in_num_q ? lead_q : 1'b1;
  // Significant mantissa digit; leading zeros are not counted
  wire dig_sig = ch_go && num_now && !in_exp_q && ch_dig && !(eff_lead && i_ch == ERQ_CH_ZERO);
  wire [19:0] exp_nx = 20'(exp_q * 20'h0000A) + {16'h0000, dig_v};

  // Header-phase faults, in priority order
  wire erq_kind_e hdr_kind =
    ch_bad ? ERQ_K_INV_CHAR :
    ((ch_col && prev_sp_q) || (ch_sp && prev_col_q)) ? ERQ_K_SYNTAX :
    ch_com ? ERQ_K_SEPAR :
    (ch_kw && hdr_len_q == ERQ_HDR_MAX) ? ERQ_K_MNEM_LONG :
    ERQ_K_NONE;
  // Parameter-phase faults, in priority order
  wire erq_kind_e prm_kind =
    ((ch_com && prev_sp_q) || ch_col) ? ERQ_K_SYNTAX :
    (gap_q && ch_numst) ? ERQ_K_SEPAR :
    (in_num_q && ch_bad) ? ERQ_K_NUM_CHAR :
    ch_bad ? ERQ_K_INV_CHAR :
    (dig_sig && dig_cnt_q == ERQ_DIG_MAX) ? ERQ_K_DIGITS :
    (in_exp_q && ch_dig && exp_nx > ERQ_EXP_MAX) ? ERQ_K_NUM_OVF :
    ERQ_K_NONE;
  // A trigger message inside an open command string
  wire get_hit = i_get && in_cmd_q;
  wire erq_kind_e ch_kind = !ch_go ? ERQ_K_NONE : (in_prm_q ? prm_kind : hdr_kind);
  // Only the first lexical fault of a command is reported
  wire lex_hit = !lex_flt_q && (get_hit || ch_kind != ERQ_K_NONE);
  wire erq_kind_e lex_kind = get_hit ? ERQ_K_GET : ch_kind;

  // Lexer has priority; decoder faults cover type, count, header and suffix
  wire push_v = lex_hit || i_dec_valid;
  wire erq_kind_e push_kind = lex_hit ? lex_kind : i_dec_kind;
  wire signed [ERQ_CODE_W-1:0] push_code =
    lex_hit ? erq_code(lex_kind, 4'h0) : erq_code(i_dec_kind, i_dec_sub);

  // Lexer next values
  wire in_prm_d = i_ch_valid ? (!i_ch_eoc && (in_prm_q || (ch_sp && !prev_col_q))) : in_prm_q;
  wire in_num_d = i_ch_valid ? (ch_go && num_now) : in_num_q;
  wire in_exp_d = i_ch_valid ? (in_num_d && in_num_q && (in_exp_q || ch_exp)) : in_exp_q;
  wire lead_d = i_ch_valid ? (ch_go && num_now && eff_lead && !dig_sig) : lead_q;
  wire gap_d = i_ch_valid ? (ch_go && ch_sp && (gap_q || in_num_q)) : gap_q;
  wire tok_st_d = i_ch_valid ? (ch_go && (ch_sp || ch_com)) : tok_st_q;
  wire lex_flt_d = (i_ch_valid && i_ch_eoc) ? 1'b0 : (lex_flt_q || lex_hit);
  assign hdr_len_d = (!i_ch_valid || in_prm_q) ? (i_ch_eoc ? 4'h0 : hdr_len_q) :
                     (i_ch_eoc || ch_col) ? 4'h0 :
                     (ch_kw && hdr_len_q != ERQ_HDR_MAX) ? hdr_len_q + 4'h1 : hdr_len_q;
  assign dig_cnt_d = !in_num_d ? 9'h000 :
                     (dig_sig && dig_cnt_q != ERQ_DIG_MAX) ? dig_cnt_q + 9'h001 : dig_cnt_q;
  assign exp_d = !in_exp_d ? 20'h00000 :
                 (ch_go && in_exp_q && ch_dig && exp_q <= ERQ_EXP_MAX) ? exp_nx : exp_q;

  // Lexer flags; the terminator returns everything to header phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      in_cmd_q <= 1'b0;
      in_prm_q <= 1'b0;
      prev_sp_q <= 1'b0;
      prev_col_q <= 1'b0;
      tok_st_q <= 1'b0;
      in_num_q <= 1'b0;
      in_exp_q <= 1'b0;
      lead_q <= 1'b0;
      gap_q <= 1'b0;
      lex_flt_q <= 1'b0;
    end else begin
      in_cmd_q <= i_ch_valid ? !i_ch_eoc : in_cmd_q;
      in_prm_q <= in_prm_d;
      prev_sp_q <= i_ch_valid ? (ch_go && ch_sp) : prev_sp_q;
      prev_col_q <= i_ch_valid ? (ch_go && ch_col && !in_prm_q) : prev_col_q;
      tok_st_q <= tok_st_d;
      in_num_q <= in_num_d;
      in_exp_q <= in_exp_d;
      lead_q <= lead_d;
      gap_q <= gap_d;
      lex_flt_q <= lex_flt_d;
    end
  end

  // Lexer counters
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      hdr_len_q <= 4'h0;
      dig_cnt_q <= 9'h000;
      exp_q <= 20'h00000;
    end else begin
      hdr_len_q <= hdr_len_d;
      dig_cnt_q <= dig_cnt_d;
      exp_q <= exp_d;
    end
  end

  // Front-panel viewer: key enters or leaves, knob restarts the idle timer
  wire view_exit = view_q && i_view_key;
  wire view_tmo = view_q && (tmr_q == P_VIEW_TMO_CYC - 32'h1);
  wire view_d = view_q ? !(view_exit || view_tmo) : i_view_key;
  // Queue clear: status clear, viewer exit or viewer timeout; device reset has no say
  wire q_clear = i_cls || view_exit || view_tmo;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      view_q <= 1'b0;
      tmr_q <= 32'h0;
    end else begin
      view_q <= view_d;
      tmr_q <= (!view_q || i_view_knob || view_exit || view_tmo) ? 32'h0 : tmr_q + 32'h1;
    end
  end

  // Remote read is taken only while no reply is being sent
  wire rd_take = i_err_rd && (tx_q == TX_IDLE);
  wire rd_pop = rd_take && !q_empty;

  erq_queue #(
    .DEPTH(DEPTH)
  ) u_queue (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_clear(q_clear),
    .i_push(push_v),
    .i_push_code(push_code),
    .i_push_kind(push_kind),
    .i_pop(rd_pop),
    .i_peek_sel(i_view_sel),
    .o_head_code(q_head_code),
    .o_head_kind(q_head_kind),
    .o_peek_code(q_peek_code),
    .o_empty(q_empty),
    .o_full(q_full),
    .o_ovf(q_ovf)
  );

  // Decimal digits of the latched code magnitude
  wire [ERQ_CODE_W-1:0] mag = (rec_code_q < 0) ? ERQ_CODE_W'(-rec_code_q) : rec_code_q;
  wire [3:0] dig_h = 4'(mag / 10'd100);
  wire [3:0] dig_t = 4'((mag / 10'd10) % 10'd10);
  wire [3:0] dig_o = 4'(mag % 10'd10);

  // Reply sequence; leading zeros are skipped, at least one digit is sent
  always_comb begin
    unique case (tx_q)
      TX_IDLE: tx_d = rd_take ? TX_SIGN : TX_IDLE;
      TX_SIGN: tx_d = (dig_h != 4'h0) ? TX_D2 : ((dig_t != 4'h0) ? TX_D1 : TX_D0);
      TX_D2: tx_d = TX_D1;
      TX_D1: tx_d = TX_D0;
      TX_D0: tx_d = TX_COMMA;
      TX_COMMA: tx_d = TX_OQ;
      TX_OQ: tx_d = TX_MSG;
      TX_MSG: tx_d = TX_CQ;
      TX_CQ: tx_d = TX_IDLE;
      // Unused codes of the 4-bit state fall back to idle
      default: tx_d = TX_IDLE;
    endcase
  end

  // Character of each reply slot; the message slot carries an index
  wire [7:0] tx_ch =
    (tx_q == TX_SIGN) ? ((rec_code_q == 0) ? ERQ_CH_PLUS : ERQ_CH_MINUS) :
    (tx_q == TX_D2) ? (ERQ_CH_ZERO | {4'h0, dig_h}) :
    (tx_q == TX_D1) ? (ERQ_CH_ZERO | {4'h0, dig_t}) :
    (tx_q == TX_D0) ? (ERQ_CH_ZERO | {4'h0, dig_o}) :
    (tx_q == TX_COMMA) ? ERQ_CH_COMMA :
    (tx_q == TX_OQ || tx_q == TX_CQ) ? ERQ_CH_QUOTE : ERQ_CH_NUL;

  // Record latch: oldest entry, or +0 with no-error index when empty
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tx_q <= TX_IDLE;
      rec_code_q <= '0;
      rec_kind_q <= ERQ_K_NONE;
    end else begin
      tx_q <= tx_d;
      if (rd_take) begin
        rec_code_q <= q_empty ? '0 : q_head_code;
        rec_kind_q <= q_empty ? ERQ_K_NONE : q_head_kind;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      beep_q <= 1'b0;
      lit_q <= 1'b0;
      txv_q <= 1'b0;
      txc_q <= ERQ_CH_NUL;
      txm_q <= 1'b0;
      txi_q <= ERQ_K_NONE;
      txl_q <= 1'b0;
      vcode_q <= '0;
      vnone_q <= 1'b0;
    end else begin
      beep_q <= push_v;
      lit_q <= !q_empty;
      txv_q <= (tx_q != TX_IDLE);
      txc_q <= tx_ch;
      txm_q <= (tx_q == TX_MSG);
      txi_q <= rec_kind_q;
      txl_q <= (tx_q == TX_CQ);
      vcode_q <= q_peek_code;
      vnone_q <= view_q && q_empty;
    end
  end

  assign o_beep = beep_q;
  assign o_err_lit = lit_q;
  assign o_tx_valid = txv_q;
  assign o_tx_char = txc_q;
  assign o_tx_msg = txm_q;
  assign o_tx_idx = txi_q;
  assign o_tx_last = txl_q;
  assign o_view_code = vcode_q;
  assign o_view_none = vnone_q;

  // Empty-queue reply: "+0," then opening quote
  sequence s_plus0;
    (o_tx_char == ERQ_CH_PLUS) ##1 (o_tx_char == ERQ_CH_ZERO) ##1 (o_tx_char == ERQ_CH_COMMA)
      ##1 (o_tx_char == ERQ_CH_QUOTE);
  endsequence

  a_empty_reply: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst) (rd_take && q_empty) |=> ##1 s_plus0)
    else $error("empty read did not answer +0");

  a_beep_per_err: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst) (push_v && q_ovf) |=> o_beep)
    else $error("no beep for a discarded error");

  a_lit_tracks: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst) (q_clear && !push_v) |=> ##1 !o_err_lit)
    else $error("indicator still lit after queue emptied");

  a_read_pops: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (rd_pop && q_full && !push_v && !q_clear) |=> !q_full)
    else $error("remote read did not remove an entry");

  a_cls_clears: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst) i_cls |=> (q_empty ##1 !o_err_lit))
    else $error("clear-status did not empty queue");

  a_tmo_clears: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst) view_tmo |=> (q_empty && !view_q))
    else $error("viewer timeout did not empty queue");

  a_hash_faults: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (ch_go && !in_prm_q && ch_bad && !lex_flt_q && !i_get) |-> push_code == -10'sh065)
    else $error("illegal header character did not give -101");

  a_long_header: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (ch_go && !in_prm_q && hdr_len_q == 4'hC && !ch_bad && ch_kw && !lex_flt_q && !i_get
     && !prev_col_q) |=> (o_beep && lex_flt_q))
    else $error("thirteenth header character not faulted");

endmodule

// ==== sim/erq_host_model.sv ====
`timescale 1ns/1ps
// Remote host: asks for one error and rebuilds the returned record
module erq_host_model import erq_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_char,
  input wire logic i_tx_msg,
  input wire erq_kind_e i_tx_idx,
  input wire logic i_tx_last,
  output logic o_err_rd
);
  initial o_err_rd = 1'b0;
  // Gap makes a slow host; message slot is kept as a tilde in the text
  task automatic query(input int gap, output int code, output erq_kind_e idx, output bit ok);
    string s;
    int n;
    s = "";
    code = 0;
    ok = 0;
    idx = ERQ_K_NONE;
    repeat (gap) @(posedge i_mclk);
    @(posedge i_mclk);
    #1 o_err_rd = 1'b1;
    @(posedge i_mclk);
    #1 o_err_rd = 1'b0;
    // Bounded: a reply longer than 40 slots is treated as lost
    for (n = 0; n < 40 && !ok; n++) begin
      if (i_tx_valid === 1'b1) begin
        if (i_tx_msg === 1'b1) begin
          idx = i_tx_idx;
          s = {s, "~"};
        end else begin
          s = {s, string'(i_tx_char)};
        end
        ok = (i_tx_last === 1'b1);
      end
      @(posedge i_mclk);
      #1;
    end
    // Sign first, then digits, then comma and the quoted message
    if (ok) ok = s.len() >= 6 && (s[0] == "+" || s[0] == "-");
    if (ok) ok = s.substr(s.len() - 4, s.len() - 1) == ",\"~\"";
    for (n = 1; ok && n < s.len() - 4; n++) begin
      if (s[n] < "0" || s[n] > "9") ok = 0;
      code = code * 10 + (s[n] - "0");
    end
    if (ok && s[0] == "-") code = -code;
  endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
// Bench for the error queue checker
module tb_top import erq_pkg::*; ();
  logic mclk = 0, rst = 1, ch_valid = 0, ch_eoc = 0, get = 0, dec_valid = 0;
  logic cls = 0, view_key = 0, view_knob = 0, err_rd;
  logic [7:0] ch = 8'h00;
  erq_kind_e dec_kind = ERQ_K_NONE;
  logic [4:0] view_sel = 5'h00;
  logic [3:0] dec_sub = 4'h3;
  logic beep, err_lit, tx_valid, tx_msg, tx_last, view_none;
  logic [7:0] tx_char;
  erq_kind_e tx_idx;
  logic signed [ERQ_CODE_W-1:0] view_code;
  int errors = 0, n_checks = 0;
  // Fault table fed through the decoder port; sub 3 picks -163 and -173
  erq_kind_e kind_t [14] = '{ERQ_K_SYNTAX, ERQ_K_SEPAR, ERQ_K_PARM_EXTRA, ERQ_K_PARM_MISS,
    ERQ_K_MNEM_LONG, ERQ_K_UNDEF_HDR, ERQ_K_NUM_OVF, ERQ_K_DIGITS, ERQ_K_NUM_NOT,
    ERQ_K_SUF_INV, ERQ_K_SUF_LONG, ERQ_K_SUF_NOT, ERQ_K_BLOCK, ERQ_K_EXPR};
  int code_t [14] = '{-102, -103, -108, -109, -112, -113, -123, -124, -128, -131, -134,
    -138, -163, -173};

  always #5 mclk = ~mclk;

  // Short timeout keeps the idle viewer case within a few dozen cycles
  erq_checker #(.P_VIEW_TMO_CYC(32'd50)) i_dut (.i_mclk(mclk), .i_sys_rst(rst),
    .i_ch_valid(ch_valid), .i_ch(ch), .i_ch_eoc(ch_eoc), .i_get(get),
    .i_dec_valid(dec_valid), .i_dec_kind(dec_kind), .i_dec_sub(dec_sub), .i_err_rd(err_rd),
    .i_cls(cls), .i_view_key(view_key), .i_view_knob(view_knob), .i_view_sel(view_sel),
    .o_beep(beep), .o_err_lit(err_lit), .o_tx_valid(tx_valid), .o_tx_char(tx_char),
    .o_tx_msg(tx_msg), .o_tx_idx(tx_idx), .o_tx_last(tx_last), .o_view_code(view_code),
    .o_view_none(view_none));

  erq_host_model i_host (.i_mclk(mclk), .i_tx_valid(tx_valid), .i_tx_char(tx_char),
    .i_tx_msg(tx_msg), .i_tx_idx(tx_idx), .i_tx_last(tx_last), .o_err_rd(err_rd));

  task automatic summarize();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input bit ok, input string what);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  // One-cycle strobe, returns just after the edge that took it
  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask

  task automatic send_ch(input logic [7:0] c, input logic e);
    @(posedge mclk);
    #1 {ch_valid, ch, ch_eoc} = {1'b1, c, e};
    @(posedge mclk);
    #1 {ch_valid, ch_eoc} = 2'b00;
  endtask

  // Whole command, then the terminator
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) send_ch(s[i], 1'b0);
    send_ch(8'h0A, 1'b1);
  endtask

  task automatic push_dec(input int i);
    dec_kind = kind_t[i];
    pulse(dec_valid);
    chk(beep === 1'b1, "no beep on new error");
  endtask

  task automatic expect_rd(input int code, input erq_kind_e k, input int gap = 0);
    int c;
    erq_kind_e idx;
    bit ok;
    i_host.query(gap, c, idx, ok);
    chk(ok, "reply malformed or lost");
    if (!ok) summarize();
    chk(c == code && idx === k, "wrong reply record");
  endtask

  task automatic s_order();
    expect_rd(0, ERQ_K_NONE);
    push_dec(5);
    send_ch(ERQ_CH_HASH, 1'b0);
    chk(beep === 1'b1, "no beep on bad char");
    send_ch(8'h0A, 1'b1);
    send_ch(8'h56, 1'b0);
    pulse(get);
    chk(beep === 1'b1, "no beep on trigger");
    send_ch(8'h0A, 1'b1);
    chk(err_lit === 1'b1, "indicator dark");
    expect_rd(-113, ERQ_K_UNDEF_HDR, 4);
    expect_rd(-101, ERQ_K_INV_CHAR);
    expect_rd(-105, ERQ_K_GET);
    repeat (2) @(posedge mclk);
    #1;
    chk(err_lit === 1'b0, "indicator lit when empty");
    expect_rd(0, ERQ_K_NONE);
  endtask

  // Faults found by the character checker itself, one per command
  task automatic s_lexer();
    send_str("VOLT:LEV , 1");
    expect_rd(-102, ERQ_K_SYNTAX);
    send_str("APPL 1.0 1.0");
    expect_rd(-103, ERQ_K_SEPAR);
    send_str("TRIG:DEL 1$");
    expect_rd(-121, ERQ_K_NUM_CHAR);
    send_str("VOLT:PROTECTIONXYZ");
    expect_rd(-112, ERQ_K_MNEM_LONG);
    send_str("VOLT 1E32001");
    expect_rd(-123, ERQ_K_NUM_OVF);
    expect_rd(0, ERQ_K_NONE);
  endtask

  // Twenty-two errors: newest slot marked, two dropped, room reopened by a read
  task automatic s_overflow();
    for (int i = 0; i < 22; i++) push_dec(i % 14);
    expect_rd(code_t[0], kind_t[0]);
    push_dec(0);
    for (int i = 1; i < 19; i++) expect_rd(code_t[i % 14], kind_t[i % 14]);
    expect_rd(-350, ERQ_K_TOO_MANY);
    expect_rd(code_t[0], kind_t[0]);
    expect_rd(0, ERQ_K_NONE);
    for (int i = 0; i < 14; i++) begin
      push_dec(i);
      expect_rd(code_t[i], kind_t[i]);
    end
    // Range member above the top is clamped to the last code
    dec_sub = 4'hF;
    push_dec(13);
    expect_rd(-178, ERQ_K_EXPR);
    dec_sub = 4'h3;
  endtask

  task automatic s_clear();
    push_dec(1);
    pulse(cls);
    expect_rd(0, ERQ_K_NONE);
    push_dec(2);
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    expect_rd(0, ERQ_K_NONE);
  endtask

  task automatic s_viewer();
    push_dec(1);
    push_dec(2);
    view_sel = 5'h01;
    pulse(view_key);
    repeat (2) @(posedge mclk);
    #1;
    chk(view_code === ERQ_CODE_W'(code_t[2]), "viewed entry");
    pulse(view_key);
    repeat (2) @(posedge mclk);
    #1;
    chk(err_lit === 1'b0, "queue kept after viewer exit");
    push_dec(3);
    pulse(view_key);
    repeat (30) @(posedge mclk);
    pulse(view_knob);
    repeat (40) @(posedge mclk);
    #1;
    chk(err_lit === 1'b1, "cleared before idle timeout");
    for (int n = 0; n < 30 && err_lit !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
    chk(err_lit === 1'b0, "idle timeout did not clear");
    if (err_lit !== 1'b0) summarize();
    pulse(view_key);
    repeat (2) @(posedge mclk);
    #1;
    chk(view_none === 1'b1, "empty viewer text");
    pulse(view_key);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    s_order();
    s_lexer();
    s_overflow();
    s_clear();
    s_viewer();
    summarize();
  end
endmodule
